// ### hw/pin_level_view_cfg.svh
// Register offsets, field positions, reset values and timer codes for the port block
`ifndef PIN_LEVEL_VIEW_CFG_SVH
`define PIN_LEVEL_VIEW_CFG_SVH

// Byte offsets within the block's AHB window
`define OFS_LATCH 8'h00
`define OFS_VIEW 8'h04
`define OFS_FSEL 8'h08
`define OFS_DIR 8'h0C

// Reset values
`define LATCH_RST 8'h00
`define DIR_RST 8'h00
`define FSEL_RST 8'h0F
`define VIEW_RST 8'h00

// Function select field positions
`define FSEL_CS17 7
`define FSEL_CS36 6
`define FSEL_CS5 5
`define FSEL_CS4 4
`define FSEL_ADDR_W 4

// Operating modes that honour the address enables
`define ADDR_MODE_LO 3'h4
`define ADDR_MODE_HI 3'h6

// Timer channel mode and control codes
`define MD_NORMAL 4'h0
`define MD_PWM1 4'h2
`define MD_PWM2 4'h3
`define MD_PHASE_TOP 2'h1
`define CCLR_NO_PWM2 2'h2
`define TPSC_CLKD 3'h7
`define PIN_TIMER 7

`endif

// ### hw/pin_level_view_pkg.sv
// Types shared by the port block
package pin_level_view_pkg;

    // Register state of the port block, apart from the pin synchroniser stages
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] fsel;
        logic [7:0] view;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic capture;
        logic clkd;
    } port_state_t;

endpackage : pin_level_view_pkg

// ### hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // Refuse a width the vectors cannot hold
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync WIDTH must be at least 1");
    end

    // First stage feeds only the second; q moves only when stages 2 and 3 agree
    always_comb begin
        next_st = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q = ((st.s2 ~^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.q);
    end

    // Frozen while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : pin_sync

// ### hw/pin_level_view_gpio_mux.sv
// Eight-bit port with output latch, pin view, address and timer pin muxing
//
// What this block does
// RL1: Output latch is 8-bit read/write, cleared by reset and hardware standby.
// RL2: Pin level view is read-only; writes there change nothing.
// RL3: View bits read latch where direction is 1, pin level where 0.
// RL4: View follows pins after reset; holds its value in software standby.
// RL5: Function select resets to 0x0F in reset and hardware standby.
// RL6: Function select bit 7 picks chip select 1 or 7 for port G bit 3.
// RL7: Function select bit 6 picks chip select 3 or 6 for port G bit 1.
// RL8: Bits 5 and 4 enable chip select 5 and 4 outputs on port F.
// RL9: Pin 3 drives address bit 23 when enable and direction are set.
// RL10: Pin 2 drives address bit 22 when enable and direction are set.
// RL11: Pin 1 drives address bit 21 when enable and direction are set.
// RL12: Pin 0 drives address bit 20 when enable and direction are set.
// RL13: Address enables act only in operating modes 4 to 6.
// RL14: Pin 7 carries timer output in output compare or PWM mode 2 setups.
// RL15: Unclaimed pin 7 is a plain port pin steered by its direction bit.
// RL16: PWM mode 1, control xx00 or clear select 10 in PWM mode 2 release pin 7.
// RL17: Pin 7 feeds timer capture in modes 0000 or 01xx with top bit set.
// RL18: Pin 7 feeds external clock D on prescaler 111 or phase counting.
// RL19: Direction bit 1 makes a pin an output, 0 an input; reset clears.
// RL20: Pin levels pass a synchroniser before reaching the read path.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_level_view_cfg.svh"
module pin_level_view_gpio_mux
    import pin_level_view_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [2:0] op_mode,
    input wire logic [3:0] addr_hi,
    input wire logic [3:0] timer_mode_field,
    input wire logic [3:0] timer_b_io_control,
    input wire logic [1:0] counter_clear_select,
    input wire logic [2:0] prescaler_select_ch0,
    input wire logic [2:0] prescaler_select_ch5,
    input wire logic [3:0] timer_ch4_mode,
    input wire logic timer_b_out,
    output logic timer_ch2_b_io,
    output logic ext_timer_clock_d,
    output logic cs_one_seven_sel,
    output logic cs_three_six_sel,
    output logic cs_five_enable,
    output logic cs_four_enable,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    localparam port_state_t ST_RESET = '{
        latch: `LATCH_RST,
        dir: `DIR_RST,
        fsel: `FSEL_RST,
        view: `VIEW_RST,
        pin_out: 8'h00,
        pin_oe: 8'h00,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b1,
        hresp: 1'b0,
        capture: 1'b0,
        clkd: 1'b0
    };

    port_state_t st;
    port_state_t next_st;
    logic [7:0] pin_sync_q;
    logic [7:0] drv_out;
    logic [7:0] drv_oe;
    logic addr_mode;
    logic md_oc_family;
    logic claim_oc;
    logic claim_pwm2;
    logic claim;
    logic cap_en;
    logic clkd_en;
    logic accept;

    // RL20 pin synchroniser
    // Pins are asynchronous to hclk, so nothing reads them before this stage
    pin_sync #(
        .WIDTH(8)
    ) pin_sync_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(pin_in),
        .q(pin_sync_q)
    );

    // RL13 mode gate
    assign addr_mode = (op_mode >= `ADDR_MODE_LO) && (op_mode <= `ADDR_MODE_HI);

    // RL14 timer claim decode
    assign md_oc_family = (timer_mode_field == `MD_NORMAL)
        || (timer_mode_field[3:2] == `MD_PHASE_TOP);
    assign claim_oc = md_oc_family && !timer_b_io_control[3]
        && (timer_b_io_control[1:0] != 2'h0);
    // RL16 release cases
    // PWM mode 1 never matches either claim term, so the direction bit rules
    assign claim_pwm2 = (timer_mode_field == `MD_PWM2)
        && (timer_b_io_control[1:0] != 2'h0)
        && (counter_clear_select != `CCLR_NO_PWM2);
    assign claim = claim_oc || claim_pwm2;

    // RL17 capture enable
    assign cap_en = md_oc_family && timer_b_io_control[3];

    // RL18 clock D enable
    assign clkd_en = (prescaler_select_ch0 == `TPSC_CLKD)
        || (prescaler_select_ch5 == `TPSC_CLKD)
        || ((timer_mode_field[3:2] == `MD_PHASE_TOP)
        && (timer_ch4_mode[3:2] == `MD_PHASE_TOP));

    // Per-pin drive selection from the current registers
    for (genvar i = 0; i < 8; i++) begin : g_pin
        if (i < `FSEL_ADDR_W) begin : g_addr
            // RL9 address pins
            // RL10 RL11 RL12 same scheme for the lower address pins
            assign drv_out[i] = (addr_mode && st.fsel[i]) ? addr_hi[i] : st.latch[i];
            // RL19 direction
            assign drv_oe[i] = st.dir[i];
        end else if (i == `PIN_TIMER) begin : g_timer
            // RL15 timer or port pin
            assign drv_out[i] = claim ? timer_b_out : st.latch[i];
            assign drv_oe[i] = claim || st.dir[i];
        end else begin : g_plain
            assign drv_out[i] = st.latch[i];
            assign drv_oe[i] = st.dir[i];
        end
    end

    assign accept = hsel && htrans[1] && hready;

    // Next-state logic: write data phase, standby, read capture, pin drive
    always_comb begin
        next_st = st;
        next_st.hresp = 1'b0;
        next_st.hreadyout = 1'b1;
        // Writes land in the data phase; software standby freezes registers
        if (st.wr_pend && !sw_standby) begin
            unique case (st.wr_addr)
                // RL1 latch write
                `OFS_LATCH: next_st.latch = hwdata[7:0];
                // RL5 function select write
                `OFS_FSEL: next_st.fsel = hwdata[7:0];
                `OFS_DIR: next_st.dir = hwdata[7:0];
                // RL2 view and unmapped writes dropped
                default: next_st.latch = st.latch;
            endcase
        end
        // RL19 hardware standby clears
        if (hw_standby) begin
            next_st.latch = `LATCH_RST;
            next_st.dir = `DIR_RST;
            next_st.fsel = `FSEL_RST;
        end
        // RL3 view mix
        // RL4 held in software standby unless hardware standby overrides
        if (!sw_standby || hw_standby) begin
            next_st.view = (next_st.dir & next_st.latch) | (~next_st.dir & pin_sync_q);
        end
        // Address phase; read data built from post-write values, so no hazard
        next_st.wr_pend = accept && hwrite;
        next_st.wr_addr = haddr[7:0];
        next_st.hrdata = 32'h0000_0000;
        if (accept && !hwrite) begin
            unique case (haddr[7:0])
                `OFS_LATCH: next_st.hrdata = {24'h00_0000, next_st.latch};
                `OFS_VIEW: next_st.hrdata = {24'h00_0000, next_st.view};
                `OFS_FSEL: next_st.hrdata = {24'h00_0000, next_st.fsel};
                default: next_st.hrdata = 32'h0000_0000;
            endcase
        end
        next_st.pin_out = drv_out;
        next_st.pin_oe = drv_oe;
        next_st.capture = cap_en && pin_sync_q[`PIN_TIMER];
        next_st.clkd = clkd_en && pin_sync_q[`PIN_TIMER];
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign hreadyout = st.hreadyout;
    assign hresp = st.hresp;
    assign hrdata = st.hrdata;
    assign pin_out = st.pin_out;
    assign pin_oe = st.pin_oe;
    assign timer_ch2_b_io = st.capture;
    assign ext_timer_clock_d = st.clkd;
    // RL6 chip select 1/7 choice
    assign cs_one_seven_sel = st.fsel[`FSEL_CS17];
    // RL7 chip select 3/6 choice
    assign cs_three_six_sel = st.fsel[`FSEL_CS36];
    // RL8 chip select 5 and 4 enables
    assign cs_five_enable = st.fsel[`FSEL_CS5];
    assign cs_four_enable = st.fsel[`FSEL_CS4];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // RL1 standby clear check
    chk_standby_clear: assert property (ce && hw_standby |=> st.latch == `LATCH_RST // RL1
        && st.fsel == `FSEL_RST && st.dir == `DIR_RST)
        else $error("standby did not clear registers");

    // RL2 view write check
    chk_view_no_write: assert property (ce && st.wr_pend && st.wr_addr == `OFS_VIEW // RL2
        && !hw_standby |=> $stable(st.latch) && $stable(st.dir) && $stable(st.fsel))
        else $error("write to view changed a register");

    // RL3 read mix check
    chk_view_read_mix: assert property (ce && accept && !hwrite && haddr[7:0] == `OFS_VIEW // RL3
        && !st.wr_pend && !sw_standby && !hw_standby
        |=> hrdata[7:0] == (($past(st.dir) & $past(st.latch))
        | (~$past(st.dir) & $past(pin_sync_q))) && hreadyout)
        else $error("view read returned wrong mix");

    // RL4 software standby hold
    chk_soft_hold: assert property (ce && sw_standby && !hw_standby |=> $stable(st.view)) // RL4
        else $error("view changed in software standby");

    // RL9 address output check
    chk_addr_drive: assert property (ce && addr_mode && st.fsel[3] && st.dir[3] // RL9
        |=> pin_out[3] == $past(addr_hi[3]) && pin_oe[3])
        else $error("pin 3 not driving address bit");

    // RL13 mode gate check
    chk_mode_gate: assert property (ce && !addr_mode // RL13
        |=> pin_out[3:0] == $past(st.latch[3:0]) && pin_oe[3:0] == $past(st.dir[3:0]))
        else $error("address enable acted outside modes 4 to 6");

    // RL14 timer claim check
    chk_timer_claim: assert property (ce && claim_pwm2 // RL14
        |=> pin_oe[7] && pin_out[7] == $past(timer_b_out))
        else $error("pin 7 not carrying timer output in PWM mode 2");

    // RL16 PWM mode 1 release check
    chk_pwm1_release: assert property (ce && timer_mode_field == `MD_PWM1 // RL16
        |=> pin_oe[7] == $past(st.dir[7]) && pin_out[7] == $past(st.latch[7]))
        else $error("pin 7 claimed in PWM mode 1");

    // RL17 capture feed check
    chk_capture_feed: assert property (ce && cap_en // RL17
        |=> timer_ch2_b_io == $past(pin_sync_q[7]))
        else $error("capture input not fed from pin 7");

    // RL18 clock D gate check
    chk_clkd_gate: assert property (ce && !clkd_en |=> !ext_timer_clock_d) // RL18
        else $error("clock D fed while not selected");

    // RL18 clock D feed check
    chk_clkd_feed: assert property (ce && clkd_en // RL18
        |=> ext_timer_clock_d == $past(pin_sync_q[7]))
        else $error("clock D not fed from pin 7");

    // RL17 capture gate check
    chk_capture_gate: assert property (ce && !cap_en |=> !timer_ch2_b_io) // RL17
        else $error("capture input fed while not enabled");

    // Zero wait states and an OKAY answer keep the master simple
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not OKAY");

    // RL1 latch write check
    chk_latch_write: assert property (ce && st.wr_pend && st.wr_addr == `OFS_LATCH // RL1
        && !sw_standby && !hw_standby |=> st.latch == $past(hwdata[7:0]))
        else $error("latch write did not land");

    // RL5 function select write check
    chk_fsel_write: assert property (ce && st.wr_pend && st.wr_addr == `OFS_FSEL // RL5
        && !sw_standby && !hw_standby |=> st.fsel == $past(hwdata[7:0]))
        else $error("function select write did not land");

    // RL14 output compare claim check, decoded from the raw timer fields
    chk_oc_claim: assert property (ce && !timer_b_io_control[3] // RL14
        && (timer_mode_field == `MD_NORMAL || timer_mode_field[3:2] == `MD_PHASE_TOP)
        && timer_b_io_control[1:0] != 2'h0
        |=> pin_oe[7] && pin_out[7] == $past(timer_b_out))
        else $error("pin 7 not carrying output compare output");

    // RL15 unclaimed pin 7 check
    chk_port_pin7: assert property (ce && !claim |=> pin_oe[7] == $past(st.dir[7]) // RL15
        && pin_out[7] == $past(st.latch[7]))
        else $error("unclaimed pin 7 not steered by its direction bit");

    // RL19 plain pins follow direction and latch
    chk_plain_dir: assert property (ce |=> pin_oe[6:4] == $past(st.dir[6:4]) // RL19
        && pin_out[6:4] == $past(st.latch[6:4]))
        else $error("pins 4 to 6 not steered by direction and latch");

    cov_view_read: cover property (accept && !hwrite && haddr[7:0] == `OFS_VIEW ##1 hreadyout);
    cov_pwm2_claim: cover property (claim_pwm2 ##1 pin_oe[7]);
    cov_addr_mode: cover property (addr_mode && st.fsel[0] && st.dir[0]);
    cov_soft_standby: cover property (sw_standby [*3]);

endmodule : pin_level_view_gpio_mux

// ### sim/pin_level_view_pins_model.sv
// Board model around the eight port pins
`timescale 1ns/1ps
module pin_level_view_pins_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // A driven pin shows the block's drive, an undriven one the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_level_view_pins_model

// ### sim/pin_level_view_gpio_mux_tb.sv
// Self-checking bench for the port block
`timescale 1ns/1ps
`include "pin_level_view_cfg.svh"
module pin_level_view_gpio_mux_tb;
    logic hclk, hresetn, hsel, hwrite, hw_standby, sw_standby, timer_b_out, cl, ce, ec, ek;
    logic hreadyout, hresp, timer_ch2_b_io, ext_timer_clock_d;
    logic cs_one_seven_sel, cs_three_six_sel, cs_five_enable, cs_four_enable;
    logic [1:0] htrans, counter_clear_select;
    logic [2:0] op_mode, prescaler_select_ch0, prescaler_select_ch5;
    logic [3:0] addr_hi, timer_mode_field, timer_b_io_control, timer_ch4_mode, am;
    logic [7:0] ext_level, pin_in, pin_out, pin_oe, eoe, eout, p, ev, cs_seen;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, r1, r2;
    int bad_count, checks_done;

    pin_level_view_gpio_mux pin_level_view_gpio_mux_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .hw_standby, .sw_standby, .op_mode, .addr_hi, .timer_mode_field, .timer_b_io_control,
        .counter_clear_select, .prescaler_select_ch0, .prescaler_select_ch5, .timer_ch4_mode,
        .timer_b_out, .timer_ch2_b_io, .ext_timer_clock_d, .cs_one_seven_sel,
        .cs_three_six_sel, .cs_five_enable, .cs_four_enable, .pin_in, .pin_out, .pin_oe);

    pin_level_view_pins_model pin_level_view_pins_model_inst (.pin_out, .pin_oe, .ext_level, .pin_in);

    // Chip select controls gathered into one byte for comparison
    assign cs_seen = {4'h0, cs_one_seven_sel, cs_three_six_sel, cs_five_enable, cs_four_enable};

    // 20 MHz clock
    always #25 hclk = ~hclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // Timer takes pin 7 in output compare or PWM mode 2 only
    function automatic logic claim(input logic [3:0] md, io, input logic [1:0] cc);
        return ((md == 4'h0 || md[3:2] == 2'h1) && !io[3] && io[1:0] != 2'h0)
            || (md == `MD_PWM2 && io[1:0] != 2'h0 && cc != `CCLR_NO_PWM2);
    endfunction : claim

    // Capture input is fed in mode 0000 or 01xx with the top B control bit set
    function automatic logic cap_on(input logic [3:0] md, io);
        return (md == 4'h0 || md[3:2] == 2'h1) && io[3];
    endfunction : cap_on

    // Clock D is fed on prescaler 111 of channel 0 or 5, or phase counting on 2 and 4
    function automatic logic clkd_on(input logic [2:0] p0, p5, input logic [3:0] m2, m4);
        return p0 == `TPSC_CLKD || p5 == `TPSC_CLKD || (m2[3:2] == 2'h1 && m4[3:2] == 2'h1);
    endfunction : clkd_on

    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // One single AHB transfer; never assumes a wait-state count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (n >= 50) begin
                bad_count++;
                end_of_test();
            end
            if (ph == 0) begin
                htrans <= 2'h0;
                hsel <= 1'b0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask : bus

    task automatic rchk(input string nm, input logic [7:0] a, e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd[7:0]);
    endtask : rchk

    // Main sequence: reset values, random mux sweep, then standby corners
    initial begin
        {hclk, hresetn, hsel, hwrite, hw_standby, sw_standby, timer_b_out} = '0;
        {htrans, counter_clear_select, op_mode, prescaler_select_ch0} = '0;
        {prescaler_select_ch5, addr_hi, timer_mode_field, timer_b_io_control} = '0;
        {timer_ch4_mode, ext_level, haddr, hwdata} = '0;
        ce = 1'b1;
        bad_count = 0;
        checks_done = 0;
        seed = 32'hF26F0F9B;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("latch", `OFS_LATCH, `LATCH_RST);
        rchk("fsel", `OFS_FSEL, `FSEL_RST);
        chk("cs", 8'h00, cs_seen);
        chk("oe", `DIR_RST, pin_oe);
        // A write to the pin view must not reach the latch
        bus(1'b1, `OFS_LATCH, 32'hA5);
        bus(1'b1, `OFS_VIEW, 32'h5A);
        rchk("latch", `OFS_LATCH, 8'hA5);
        // Clock enable low freezes all state, so this write never lands
        ce <= 1'b0;
        bus(1'b1, `OFS_LATCH, 32'h0F);
        ce <= 1'b1;
        rchk("latch", `OFS_LATCH, 8'hA5);
        for (int k = 0; k < 60; k++) begin
            seed = xs(seed);
            r1 = seed;
            seed = xs(seed);
            r2 = seed;
            {timer_b_out, prescaler_select_ch5, prescaler_select_ch0} <= r1[31:25];
            {counter_clear_select, timer_b_io_control, timer_mode_field} <= r1[24:15];
            {addr_hi, op_mode, ext_level} <= r1[14:0];
            timer_ch4_mode <= r2[27:24];
            bus(1'b1, `OFS_FSEL, r2[7:0]);
            bus(1'b1, `OFS_LATCH, r2[15:8]);
            bus(1'b1, `OFS_DIR, r2[23:16]);
            repeat (10) @(posedge hclk);
            cl = claim(r1[18:15], r1[22:19], r1[24:23]);
            eoe = {cl | r2[23], r2[22:16]};
            am = (r1[10:8] >= `ADDR_MODE_LO && r1[10:8] <= `ADDR_MODE_HI) ? r2[3:0] : 4'h0;
            eout = {cl ? r1[31] : r2[15], r2[14:12], (am & r1[14:11]) | (~am & r2[11:8])};
            p = (eoe & eout) | (~eoe & r1[7:0]);
            ev = (r2[23:16] & r2[15:8]) | (~r2[23:16] & p);
            chk("oe", eoe, pin_oe);
            chk("out", eout & eoe, pin_out & pin_oe);
            ec = cap_on(r1[18:15], r1[22:19]) & p[7];
            ek = clkd_on(r1[27:25], r1[30:28], r1[18:15], r2[27:24]) & p[7];
            chk("cs", {4'h0, r2[7:4]}, cs_seen);
            chk("cap", {7'h0, ec}, {7'h0, timer_ch2_b_io});
            chk("clkd", {7'h0, ek}, {7'h0, ext_timer_clock_d});
            rchk("view", `OFS_VIEW, ev);
            rchk("fsel", `OFS_FSEL, r2[7:0]);
        end
        // Software standby holds latch and view against writes and pin moves
        sw_standby <= 1'b1;
        bus(1'b1, `OFS_LATCH, 32'h3C);
        ext_level <= ~r1[7:0];
        repeat (10) @(posedge hclk);
        rchk("latch", `OFS_LATCH, r2[15:8]);
        rchk("view", `OFS_VIEW, ev);
        // Hardware standby restores reset values; view then follows pins
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        timer_mode_field <= `MD_PWM1;
        repeat (3) @(posedge hclk);
        hw_standby <= 1'b0;
        repeat (10) @(posedge hclk);
        rchk("latch", `OFS_LATCH, `LATCH_RST);
        rchk("fsel", `OFS_FSEL, `FSEL_RST);
        rchk("view", `OFS_VIEW, ~r1[7:0]);
        // A second reset in mid-run restores the function select value
        bus(1'b1, `OFS_FSEL, 32'hF0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("fsel", `OFS_FSEL, `FSEL_RST);
        chk("cs", 8'h00, cs_seen);
        end_of_test();
    end
endmodule : pin_level_view_gpio_mux_tb
